// file: hdl/spipr_map.vh
/*
  Constants for the SPI pin-role and select-mode block.
  Assumes inclusion by the design files of this block only.
*/
`ifndef SPIPR_MAP_VH
`define SPIPR_MAP_VH
// Select-mode field encodings.
`define SPIPR_SEL_3WIRE 2'h0
`define SPIPR_SEL_4WIRE_IN 2'h1
`define SPIPR_SEL_HI_BIT 1
`define SPIPR_SEL_LO_BIT 0
// Byte geometry.
`define SPIPR_BYTE_BITS 4'h8
`define SPIPR_DATA_W 8
// Master clock divider: half period of the serial clock in core cycles.
`define SPIPR_HALF_PERIOD_NS 50
`define SPIPR_CLK_PERIOD_NS 10
`define SPIPR_HALF_CYCLES (`SPIPR_HALF_PERIOD_NS / `SPIPR_CLK_PERIOD_NS)
// Last divider count of a half period (five core cycles), at divider width.
`define SPIPR_HALF_LAST 8'h04
// Buffer depth.
`define SPIPR_FIFO_DEPTH 8
`define SPIPR_FIFO_AW 3
`endif

// file: hdl/spipr_fifo.v
/*
  Small synchronous FIFO with valid and ready on both sides.
  Assumes one clock, a synchronous active-low reset and a clock enable.
*/
`timescale 1ns/1ps
module spipr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clocking.
  input wire core_clk,
  input wire rst_n,
  input wire clkEn,
  // Fill side.
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side.
  output wire outValid,
  input wire outReady,
  output reg [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  reg outValid_q;
  wire doWrite;
  wire doRead;
  wire memHas;
  wire loadOut;
  wire [AW:0] fill;

  //////////////////////////////////////////////////////////////////////
  // count_q counts words in memory; the output register holds one more.
  // Ready stays low once both together hold DEPTH words.
  assign memHas = (count_q != {(AW+1){1'b0}});
  assign fill = count_q + {{AW{1'b0}}, outValid_q};
  assign inReady = (fill != DEPTH[AW:0]);
  assign doWrite = inValid && inReady;
  assign outValid = outValid_q;
  assign loadOut = memHas && (!outValid_q || outReady);
  assign doRead = loadOut;

  // Memory write and pointer bookkeeping.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      outValid_q <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end else if (clkEn) begin
      if (doWrite) begin
        mem[wrPtr_q] <= inData;
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRead) begin
        outData <= mem[rdPtr_q];
        rdPtr_q <= rdPtr_q + 1'b1;
        outValid_q <= 1'b1;
      end else if (outReady) begin
        outValid_q <= 1'b0;
      end
      if (doWrite && !doRead) begin
        count_q <= count_q + 1'b1;
      end else if (!doWrite && doRead) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // spipr_fifo

// file: hdl/spipr_sync.v
/*
  Two-flop synchroniser for a bundle of asynchronous inputs.
  Assumes the inputs are levels from outside the core clock domain.
*/
`timescale 1ns/1ps
module spipr_sync #(
  parameter WIDTH = 3
) (
  // Clocking.
  input wire core_clk,
  input wire rst_n,
  input wire clkEn,
  // Data.
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] meta_q;

  //////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage. Reset value is idle high.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{1'b1}};
      syncOut <= {WIDTH{1'b1}};
    end else if (clkEn) begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // spipr_sync

// file: hdl/spipr_core.v
/*
  SPI port pin roles and select modes: master and slave byte shifting,
  data-line direction, select input/output handling and pin routing.
  Assumes an external SPI master or slave; all pins except outputs are
  asynchronous to core_clk. Serial clock idles low, data sampled on rising
  edge; changed on the falling edge by the master and a few core cycles after the rising edge by the slave. The pin-level tri-state buffers and
  the pin routing sit outside this block and obey the enable outputs.
  clkEn low freezes every register, the synchronisers included.
*/
`timescale 1ns/1ps
`include "spipr_map.vh"
module spipr_core (
  // Clock, reset and enable.
  input wire core_clk,
  input wire rst_n,
  input wire clkEn,
  // Configuration bits.
  input wire portEnable,
  input wire master_role_enable,
  input wire [1:0] select_mode_field,
  // Transmit stream into the FIFO.
  input wire txValid,
  output wire txReady,
  input wire [7:0] txData,
  // Received bytes.
  output reg rxValid,
  output reg [7:0] rxData,
  // Status.
  output reg masterActive,
  output reg modeFault,
  output reg busy,
  output reg selectRouted,
  // Master-to-slave data pin.
  input wire mosiIn,
  output reg mosiOut,
  output reg mosiOe,
  // Slave-to-master data pin.
  input wire misoIn,
  output reg misoOut,
  output reg misoOe,
  // Serial clock pin.
  input wire sckIn,
  output reg sckOut,
  output reg sckOe,
  // Select pin, active low.
  input wire selInN,
  output reg selOutN,
  output reg selOeN
);
  // Synchronised pins: bit 0 sck, 1 mosi, 2 miso, 3 select.
  wire [3:0] pinSync;
  wire sckS;
  wire mosiS;
  wire misoS;
  wire selS;
  reg sckPrev_q;
  reg selPrev_q;
  reg mstDis_q;
  // Shift engine state.
  reg [7:0] shift_q;
  reg [3:0] bitCnt_q;
  reg loaded_q;
  reg [7:0] divCnt_q;
  reg sckGen_q;
  reg mstRun_q;
  reg sampleBit_q;
  wire fifoValid;
  wire [7:0] fifoData;
  wire fifoPop;
  // Decode and edge strobes.
  wire isMaster;
  wire isSlave;
  wire mode3;
  wire mode4in;
  wire modeOut;
  wire slvSelected;
  wire sckRise;
  wire selFall;
  wire halfDone;
  wire [7:0] shiftNext;

  //////////////////////////////////////////////////////////////////////
  // Shift left and append an incoming bit at the bottom.
  // Used by both roles so that the bit order cannot drift apart.
  function [7:0] shiftIn;
    input [7:0] cur;
    input inBit;
    begin
      shiftIn = {cur[6:0], inBit};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Pin inputs pass two flops before use.
  // Select and serial clock also feed edge detectors below.
  spipr_sync #(
    .WIDTH(4)
  ) uSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .asyncIn({selInN, misoIn, mosiIn, sckIn}),
    .syncOut(pinSync)
  );
  assign sckS = pinSync[0];
  assign mosiS = pinSync[1];
  assign misoS = pinSync[2];
  assign selS = pinSync[3];

  // Transmit bytes wait in the FIFO until the shift register takes them.
  // A word is popped only while the shift register is empty.
  spipr_fifo #(
    .WIDTH(`SPIPR_DATA_W),
    .DEPTH(`SPIPR_FIFO_DEPTH),
    .AW(`SPIPR_FIFO_AW)
  ) uFifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .inValid(txValid),
    .inReady(txReady),
    .inData(txData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  //////////////////////////////////////////////////////////////////////
  // Role and mode decode.
  // A master that took a mode fault stays off until software re-arms it.
  assign mode3 = (select_mode_field == `SPIPR_SEL_3WIRE);
  assign mode4in = (select_mode_field == `SPIPR_SEL_4WIRE_IN);
  assign modeOut = select_mode_field[`SPIPR_SEL_HI_BIT];
  assign isMaster = portEnable && master_role_enable && !mstDis_q;
  assign isSlave = portEnable && !master_role_enable;
  // 3-wire slave is always selected; 4-wire input-mode slave selected by low input; output modes never select.
  assign slvSelected = mode3 || (mode4in && !selS);
  // Edges are found on the synchronised copies only.
  assign sckRise = sckS && !sckPrev_q;
  assign selFall = !selS && selPrev_q;
  // Divider end point, sized to the divider counter.
  assign halfDone = (divCnt_q == `SPIPR_HALF_LAST);
  assign fifoPop = fifoValid && !loaded_q && (isMaster || isSlave);
  assign shiftNext = shiftIn(shift_q, isMaster ? misoS : mosiS);

  //////////////////////////////////////////////////////////////////////
  // Edge history of synchronised serial clock and select.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      // Both reset high like the synchroniser, so no false edge follows.
      sckPrev_q <= 1'b1;
      selPrev_q <= 1'b1;
    end else if (clkEn) begin
      sckPrev_q <= sckS;
      selPrev_q <= selS;
    end
  end

  // Multi-master lockout: a falling select in 4-wire input mode drops the master function.
  // The fault flag is sticky until the role or the port is dropped.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      mstDis_q <= 1'b0;
      modeFault <= 1'b0;
    end else if (clkEn) begin
      if (!portEnable || !master_role_enable) begin
        mstDis_q <= 1'b0;
        modeFault <= 1'b0;
      end else if (mode4in && selFall) begin
        mstDis_q <= 1'b1;
        modeFault <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Shift engine for both roles.
  // Master: a divider makes the serial clock; bits move on its falling half.
  // Slave: bits move on each synchronised rising edge of the pin clock while selected.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      shift_q <= 8'h00;
      bitCnt_q <= 4'h0;
      loaded_q <= 1'b0;
      divCnt_q <= 8'h00;
      sckGen_q <= 1'b0;
      mstRun_q <= 1'b0;
      sampleBit_q <= 1'b0;
      rxValid <= 1'b0;
      rxData <= 8'h00;
    end else if (clkEn) begin
      rxValid <= 1'b0;
      if (!isMaster && !isSlave) begin
        // Disabling clears the bit counter; in 3-wire slave only this, a FIFO load and a finished byte reset it.
        bitCnt_q <= 4'h0;
        loaded_q <= 1'b0;
        mstRun_q <= 1'b0;
        sckGen_q <= 1'b0;
        divCnt_q <= 8'h00;
      end else if (fifoPop) begin
        shift_q <= fifoData;
        loaded_q <= 1'b1;
        bitCnt_q <= 4'h0;
        mstRun_q <= isMaster;
      end else if (isMaster) begin
        if (mstRun_q) begin
          if (halfDone) begin
            divCnt_q <= 8'h00;
            sckGen_q <= !sckGen_q;
            if (!sckGen_q) begin
              // Rising half: take the slave's bit but leave the MSB on the
              // data line, so that it stands through the whole high phase.
              sampleBit_q <= misoS;
              bitCnt_q <= bitCnt_q + 4'h1;
            end else begin
              // Falling half: shift, which moves the next bit onto the line.
              shift_q <= shiftIn(shift_q, sampleBit_q);
              if (bitCnt_q == `SPIPR_BYTE_BITS) begin
                mstRun_q <= 1'b0;
                loaded_q <= 1'b0;
                bitCnt_q <= 4'h0;
                rxValid <= 1'b1;
                rxData <= shiftIn(shift_q, sampleBit_q);
              end
            end
          end else begin
            divCnt_q <= divCnt_q + 8'h01;
          end
        end
      end else begin
        // Slave: a new select falling edge restarts the byte.
        // In 3-wire mode only disabling the port, a FIFO load or a finished byte clears the count.
        if (mode4in && selFall) begin
          bitCnt_q <= 4'h0;
        // Deselected: the register and the count hold still.
        end else if (slvSelected && sckRise) begin
          shift_q <= shiftNext;
          if (bitCnt_q == (`SPIPR_BYTE_BITS - 4'h1)) begin
            bitCnt_q <= 4'h0;
            loaded_q <= 1'b0;
            rxValid <= 1'b1;
            rxData <= shiftNext;
          end else begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin drivers and status, all registered.
  // selOeN is high while the select pin is driven, despite its name.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      mosiOut <= 1'b0;
      mosiOe <= 1'b0;
      misoOut <= 1'b0;
      misoOe <= 1'b0;
      sckOut <= 1'b0;
      sckOe <= 1'b0;
      selOutN <= 1'b1;
      selOeN <= 1'b0;
      selectRouted <= 1'b0;
      masterActive <= 1'b0;
      busy <= 1'b0;
    end else if (clkEn) begin
      mosiOut <= shift_q[7];
      mosiOe <= isMaster;
      misoOut <= shift_q[7];
      misoOe <= isSlave && slvSelected;
      sckOut <= sckGen_q;
      sckOe <= isMaster;
      selOutN <= select_mode_field[`SPIPR_SEL_LO_BIT];
      selOeN <= portEnable && modeOut;
      selectRouted <= !mode3;
      masterActive <= isMaster;
      busy <= loaded_q;
    end
  end
endmodule // spipr_core

// file: test/spipr_core_properties.sv
/*
  Concurrent checks on the pin roles and select modes of spipr_core.
  Assumes it is bound to spipr_core and sees only its ports.
*/
`timescale 1ns/1ps
module spipr_core_properties (
  // Clock and reset.
  input wire core_clk,
  input wire rst_n,
  // Configuration and select pin.
  input wire portEnable,
  input wire master_role_enable,
  input wire [1:0] select_mode_field,
  input wire selInN,
  // Observed outputs.
  input wire rxValid,
  input wire modeFault,
  input wire selectRouted,
  input wire mosiOut,
  input wire mosiOe,
  input wire misoOe,
  input wire sckOut,
  input wire sckOe,
  input wire selOutN,
  input wire selOeN
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Pin directions follow the role one cycle after it is set.
  mosi_role_a: assert property (mosiOe |-> $past(portEnable && master_role_enable))
    else $error("mosi driven outside master role");
  miso_role_a: assert property (misoOe |-> $past(portEnable && !master_role_enable))
    else $error("miso driven outside slave role");
  miso_off_a: assert property (!portEnable |=> !misoOe)
    else $error("miso driven while disabled");
  miso_unsel_a: assert property ((select_mode_field == 2'h1 && selInN)[*4] |=> !misoOe)
    else $error("miso driven while deselected");
  miso_3w_a: assert property ((portEnable && !master_role_enable &&
    select_mode_field == 2'h0)[*2] |=> misoOe)
    else $error("three-wire slave not driving miso");
  sck_role_a: assert property (sckOe |-> $past(master_role_enable))
    else $error("serial clock driven as slave");
  mosi_hold_a: assert property (mosiOe && sckOut |-> $stable(mosiOut))
    else $error("mosi changed while clock high");
  sel_drive_a: assert property ($past(rst_n && portEnable && select_mode_field[1]) |-> selOeN)
    else $error("select not driven in output mode");
  sel_level_a: assert property (selOeN |-> selOutN == $past(select_mode_field[0]))
    else $error("select level differs from low bit");
  sel_route_a: assert property (selectRouted |-> $past(select_mode_field) != 2'h0)
    else $error("select routed in three-wire mode");
  fault_stop_a: assert property ($past(modeFault) |-> !sckOe && !mosiOe)
    else $error("master still driving after fault");
  rx_pulse_a: assert property (rxValid |=> !rxValid)
    else $error("byte strobe longer than one cycle");
endmodule // spipr_core_properties
bind spipr_core spipr_core_properties PROPS (.core_clk(core_clk), .rst_n(rst_n),
  .portEnable(portEnable), .master_role_enable(master_role_enable),
  .select_mode_field(select_mode_field), .selInN(selInN), .rxValid(rxValid),
  .modeFault(modeFault), .selectRouted(selectRouted), .mosiOut(mosiOut), .mosiOe(mosiOe),
  .misoOe(misoOe), .sckOut(sckOut), .sckOe(sckOe), .selOutN(selOutN), .selOeN(selOeN));

// file: test/spipr_far_end.sv
/*
  Far-side SPI model: a slave that answers the port, and a master task.
  Assumes mode 0 timing and resolved wires from the testbench.
*/
`timescale 1ns/1ps
module spipr_far_end (
  // Resolved bus wires.
  input wire sck,
  input wire mosi,
  input wire miso,
  // Far-side drivers.
  output reg farSck,
  output reg farMosi,
  output wire farMiso
);
  reg [7:0] slvQ;
  reg [7:0] mGot;
  reg [7:0] sGot;
  initial begin
    farSck = 1'h0;
    farMosi = 1'h0;
    slvQ = 8'h00;
  end
  // Both lines are captured on the rising clock, first bit into the top.
  always @(posedge sck) begin
    mGot <= {mGot[6:0], mosi};
    sGot <= {sGot[6:0], miso};
  end
  // The slave shifts on the falling clock; the fill bit keeps toggling.
  always @(negedge sck) begin
    slvQ <= {slvQ[6:0], ~slvQ[0]};
  end
  assign farMiso = slvQ[7];
  task load(input [7:0] b);
    slvQ = b;
  endtask
  // Master frame at 125 ns per bit; the clock stands low between frames.
  task send(input [7:0] b);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      farMosi = b[i];
      #62.5 farSck = 1'h1;
      #62.5 farSck = 1'h0;
    end
    farMosi = ~b[0];
  endtask
endmodule // spipr_far_end

// file: test/testbench.sv
/*
  Self-checking bench for spipr_core in master, slave and select modes.
  Assumes the far-end model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  reg core_clk = 1'h0;
  reg rst_n = 1'h0;
  reg portEnable = 1'h0;
  reg master_role_enable = 1'h0;
  reg [1:0] select_mode_field = 2'h0;
  reg txValid = 1'h0;
  reg [7:0] txData = 8'h00;
  reg tbSelN = 1'h1;
  reg clkEn = 1'h1;
  reg [7:0] rxSeen = 8'h00;
  integer num_errors = 0;
  integer comparisons = 0;
  integer rxCnt = 0;
  integer n;
  integer k;
  wire txReady, rxValid, masterActive, modeFault, busy, selectRouted;
  wire [7:0] rxData;
  wire mosiOut, mosiOe, misoOut, misoOe, sckOut, sckOe, selOutN, selOeN;
  wire farSck, farMosi, farMiso;
  // Each wire takes the level of whichever side enables its driver.
  wire mosiW = mosiOe ? mosiOut : farMosi;
  wire misoW = misoOe ? misoOut : farMiso;
  wire sckW = sckOe ? sckOut : farSck;
  wire selW = selOeN ? selOutN : tbSelN;
  spipr_core DUT (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .portEnable(portEnable),
    .master_role_enable(master_role_enable), .select_mode_field(select_mode_field),
    .txValid(txValid), .txReady(txReady), .txData(txData), .rxValid(rxValid), .rxData(rxData),
    .masterActive(masterActive), .modeFault(modeFault), .busy(busy),
    .selectRouted(selectRouted), .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe),
    .misoIn(misoW), .misoOut(misoOut), .misoOe(misoOe), .sckIn(sckW), .sckOut(sckOut),
    .sckOe(sckOe), .selInN(selW), .selOutN(selOutN), .selOeN(selOeN));
  spipr_far_end FAR (.sck(sckW), .mosi(mosiW), .miso(misoW), .farSck(farSck),
    .farMosi(farMosi), .farMiso(farMiso));
  always #5 core_clk = ~core_clk;
  // Received bytes are latched and counted.
  always @(posedge core_clk) if (rxValid === 1'h1) begin
    rxSeen <= rxData;
    rxCnt <= rxCnt + 1;
  end
  task check(input string what, input [7:0] exp, input [7:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      num_errors = num_errors + 1;
    end
  endtask
  task cfg(input e, input m, input [1:0] md);
    @(posedge core_clk);
    #1 portEnable = e;
    master_role_enable = m;
    select_mode_field = md;
    repeat (6) @(posedge core_clk);
    #1;
  endtask
  task push(input [7:0] b);
    @(posedge core_clk);
    #1 txValid = 1'h1;
    txData = b;
    @(posedge core_clk);
    while (txReady !== 1'h1) @(posedge core_clk);
    #1 txValid = 1'h0;
  endtask
  task wait_rx(input integer was);
    k = 0;
    while (rxCnt == was && k < 400) begin
      @(posedge core_clk);
      k = k + 1;
    end
    #1;
    if (rxCnt == was) begin
      $display("Error rxCount expected %0d seen %0d", was + 1, rxCnt);
      num_errors = num_errors + 1;
    end
  endtask
  task final_report;
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard, well beyond the expected length of the run.
  initial begin
    #500000;
    num_errors = num_errors + 1;
    final_report;
  end
  // Test sequence.
  initial begin
    repeat (6) @(posedge core_clk);
    #1 rst_n = 1'h1;
    FAR.load(8'h3C);
    cfg(1'h1, 1'h1, 2'h0);
    check("mosiOe", 8'h01, mosiOe);
    check("misoOe", 8'h00, misoOe);
    check("masterActive", 8'h01, masterActive);
    n = rxCnt;
    push(8'hA5);
    wait_rx(n);
    check("masterRx", 8'h3C, rxSeen);
    check("mosiBits", 8'hA5, FAR.mGot);
    check("busyIdle", 8'h00, busy);
    cfg(1'h1, 1'h0, 2'h0);
    check("misoOe3w", 8'h01, misoOe);
    check("sckOe", 8'h00, sckOe);
    check("routed3w", 8'h00, selectRouted);
    push(8'h96);
    n = rxCnt;
    FAR.send(8'h5A);
    wait_rx(n);
    check("slaveRx", 8'h5A, rxSeen);
    check("misoBits", 8'h96, FAR.sGot);
    cfg(1'h1, 1'h0, 2'h1);
    check("misoOeUnsel", 8'h00, misoOe);
    n = rxCnt;
    FAR.send(8'hFF);
    repeat (10) @(posedge core_clk);
    #1 check("ignoredBytes", n[7:0], rxCnt[7:0]);
    tbSelN = 1'h0;
    repeat (4) @(posedge core_clk);
    #1 check("misoOeSel", 8'h01, misoOe);
    FAR.send(8'hC3);
    wait_rx(n);
    check("selectedRx", 8'hC3, rxSeen);
    // The frame sent while deselected must not have touched the register.
    check("heldShift", 8'h5A, FAR.sGot);
    tbSelN = 1'h1;
    for (k = 2; k < 4; k = k + 1) begin
      cfg(1'h1, 1'h1, k[1:0]);
      check("selOeN", 8'h01, selOeN);
      check("selOutN", {7'h00, k[0]}, selOutN);
      check("routed4w", 8'h01, selectRouted);
    end
    cfg(1'h1, 1'h1, 2'h1);
    tbSelN = 1'h0;
    repeat (6) @(posedge core_clk);
    #1 check("modeFault", 8'h01, modeFault);
    check("sckOeFault", 8'h00, sckOe);
    tbSelN = 1'h1;
    cfg(1'h0, 1'h0, 2'h1);
    check("misoOeOff", 8'h00, misoOe);
    check("mosiOeOff", 8'h00, mosiOe);
    // Fill the buffer with the slave deselected until it refuses.
    cfg(1'h1, 1'h0, 2'h1);
    txValid = 1'h1;
    k = 0;
    while (txReady === 1'h1 && k < 12) begin
      @(posedge core_clk);
      #1 k = k + 1;
    end
    txValid = 1'h0;
    // Eight words wait in the buffer and a ninth sits in the shift register.
    check("fillDepth", 8'h09, k[7:0]);
    check("busyLoaded", 8'h01, busy);
    // With the clock enable low nothing moves, not even a port disable.
    clkEn = 1'h0;
    portEnable = 1'h0;
    repeat (4) @(posedge core_clk);
    #1 check("busyFrozen", 8'h01, busy);
    final_report;
  end
endmodule // testbench
